// ==== rtl/dpg_gpio.sv ====
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "dpg_regs.svh"

module dpg_gpio (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Wide port pins
    input wire logic [`DPG_WIDE_W-1:0] wide_pin_in,
    output logic [`DPG_WIDE_W-1:0] wide_pin_out,
    output logic [`DPG_WIDE_W-1:0] wide_pin_oe,
    output logic [`DPG_WIDE_W-1:0] wide_pin_pulldown,
    // Narrow port pins
    input wire logic [`DPG_NARROW_W-1:0] narrow_pin_in,
    output logic [`DPG_NARROW_W-1:0] narrow_pin_out,
    output logic [`DPG_NARROW_W-1:0] narrow_pin_oe,
    output logic [`DPG_NARROW_W-1:0] narrow_pin_pulldown,
    // Interrupt
    input wire logic irq_n_pin,
    output logic irq_request,
    output logic irq_pin_level
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Per bit: driven data for outputs, live pin for inputs
    function automatic logic [7:0] pin_view(input logic [7:0] dir, input logic [7:0] data,
                                             input logic [7:0] pin);
        pin_view = (dir & data) | (~dir & pin);
    endfunction

    // Pulldown control for a group of pins
    function automatic logic [7:0] pull_of(input logic en, input logic [7:0] dir,
                                            input logic [7:0] pdi);
        pull_of = en ? (~pdi & ~dir) : 8'h00;
    endfunction

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    dpg_pkg::dpg_state_s q;
    dpg_pkg::dpg_state_s next_q;

    logic [9:0] idx;
    logic setup;
    logic wr_done;
    logic wr_lane0;
    logic opt_pd;
    logic opt_pint;
    logic opt_edge;
    logic opt_osc;
    logic active;
    logic [7:0] narrow_rd;
    logic [7:0] narrow_eff_dir;
    logic [7:0] narrow_pull_full;

    assign idx = paddr[11:2];
    assign setup = psel & ~penable;
    assign wr_done = psel & penable & q.pready & pwrite;
    assign wr_lane0 = wr_done & pstrb[0];
    assign opt_pd = q.option[`DPG_OPT_PULLDOWN_EN];
    assign opt_pint = q.option[`DPG_OPT_PORT_IRQ_EN];
    assign opt_edge = q.option[`DPG_OPT_EDGE_ONLY];
    assign opt_osc = q.option[`DPG_OPT_RC_OSC];

    // Port pins are taken at their level regardless of direction
    assign active = ~irq_n_pin | (opt_pint & (|wide_pin_in[3:0]));

    // Oscillator pin reads back its stored bit, like an output
    assign narrow_eff_dir = {6'h00, q.narrow_dir[1] | opt_osc, q.narrow_dir[0]};
    assign narrow_rd = pin_view(narrow_eff_dir, {6'h00, q.narrow_data},
                                {6'h00, narrow_pin_in}) & 8'h03;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        next_q = q;
        next_q.pready = 1'b0;
        next_q.pslverr = 1'b0;

        // Answer in the first access cycle
        if (setup) begin
            next_q.pready = 1'b1;
            next_q.prdata = 32'h0000_0000;
            unique case (idx)
                `DPG_IDX_WIDE_DATA: begin
                    next_q.prdata = {24'h00_0000,
                                     pin_view(q.wide_dir, q.wide_data, wide_pin_in)};
                end
                `DPG_IDX_NARROW_DATA: begin
                    next_q.prdata = {24'h00_0000, narrow_rd};
                end
                `DPG_IDX_WIDE_DIR: begin
                    next_q.prdata = {24'h00_0000, q.wide_dir};
                end
                `DPG_IDX_NARROW_DIR: begin
                    next_q.prdata = {30'h0000_0000, q.narrow_dir};
                end
                `DPG_IDX_WIDE_PDI, `DPG_IDX_NARROW_PDI: begin
                    next_q.prdata = 32'h0000_0000;
                end
                `DPG_IDX_OPTION: begin
                    next_q.prdata = {28'h000_0000, q.option};
                end
                `DPG_IDX_IRQ_STATUS: begin
                    next_q.prdata = {29'h0000_0000, active, q.irq_pin_level, q.irq_latch};
                end
                default: begin
                    next_q.pslverr = 1'b1;
                end
            endcase
        end

        // Writes land at the completing edge
        if (wr_lane0) begin
            unique case (idx)
                `DPG_IDX_WIDE_DATA: next_q.wide_data = pwdata[7:0];
                `DPG_IDX_NARROW_DATA: next_q.narrow_data = pwdata[1:0];
                `DPG_IDX_WIDE_DIR: next_q.wide_dir = pwdata[7:0];
                `DPG_IDX_NARROW_DIR: next_q.narrow_dir = pwdata[1:0];
                `DPG_IDX_WIDE_PDI: next_q.wide_pdi = pwdata[7:0];
                `DPG_IDX_NARROW_PDI: next_q.narrow_pdi = pwdata[1:0];
                `DPG_IDX_OPTION: next_q.option = pwdata[`DPG_OPT_W-1:0];
                default: begin
                end
            endcase
        end

        // Pulldowns from the values about to be registered
        next_q.wide_pull = pull_of(next_q.option[`DPG_OPT_PULLDOWN_EN],
                                   next_q.wide_dir, next_q.wide_pdi);
        narrow_pull_full = pull_of(next_q.option[`DPG_OPT_PULLDOWN_EN],
                                   {6'h00, next_q.narrow_dir},
                                   {6'h00, next_q.narrow_pdi});
        next_q.narrow_pull = narrow_pull_full[1:0];
        if (next_q.option[`DPG_OPT_RC_OSC]) begin
            next_q.narrow_pull[`DPG_OSC_PIN] = 1'b0;
        end

        // Interrupt latch: clear by writing one, a new edge wins
        if (wr_lane0 && idx == `DPG_IDX_IRQ_STATUS && pwdata[`DPG_STS_LATCH]) begin
            next_q.irq_latch = 1'b0;
        end
        next_q.active_prev = active;
        if (active && !q.active_prev) begin
            next_q.irq_latch = 1'b1;
        end
        next_q.irq_req = next_q.irq_latch | (~opt_edge & active);
        next_q.irq_pin_level = irq_n_pin;
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Data registers are left alone
            q.wide_dir <= `DPG_RST_WIDE;
            q.narrow_dir <= `DPG_RST_NARROW;
            q.wide_pdi <= `DPG_RST_WIDE;
            q.narrow_pdi <= `DPG_RST_NARROW;
            q.option <= `DPG_RST_OPTION;
            q.wide_pull <= `DPG_RST_WIDE;
            q.narrow_pull <= `DPG_RST_NARROW;
            q.irq_latch <= 1'b0;
            q.active_prev <= 1'b0;
            q.irq_req <= 1'b0;
            q.irq_pin_level <= 1'b1;
            q.pready <= 1'b0;
            q.pslverr <= 1'b0;
            q.prdata <= 32'h0000_0000;
        end else begin
            q <= next_q;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign wide_pin_out = q.wide_data;
    assign wide_pin_oe = q.wide_dir;
    assign wide_pin_pulldown = q.wide_pull;
    assign narrow_pin_out = q.narrow_data;
    assign narrow_pin_oe = q.narrow_dir;
    assign narrow_pin_pulldown = q.narrow_pull;
    assign irq_request = q.irq_req;
    assign irq_pin_level = q.irq_pin_level;

endmodule

// ==== shared/dpg_regs.svh ====
`ifndef DPG_REGS_SVH
`define DPG_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define DPG_IDX_WIDE_DATA 10'h000
`define DPG_IDX_NARROW_DATA 10'h001
`define DPG_IDX_WIDE_DIR 10'h004
`define DPG_IDX_NARROW_DIR 10'h005
`define DPG_IDX_WIDE_PDI 10'h010
`define DPG_IDX_NARROW_PDI 10'h011
`define DPG_IDX_OPTION 10'h014
`define DPG_IDX_IRQ_STATUS 10'h015

// ----------------------------------------------------------------------------
// Widths and field positions
// ----------------------------------------------------------------------------
`define DPG_WIDE_W 8
`define DPG_NARROW_W 2
`define DPG_OSC_PIN 1
`define DPG_OPT_PULLDOWN_EN 0
`define DPG_OPT_PORT_IRQ_EN 1
`define DPG_OPT_EDGE_ONLY 2
`define DPG_OPT_RC_OSC 3
`define DPG_OPT_W 4
`define DPG_STS_LATCH 0
`define DPG_STS_IRQ_PIN 1
`define DPG_STS_ACTIVE 2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define DPG_RST_WIDE 8'h00
`define DPG_RST_NARROW 2'h0
`define DPG_RST_OPTION 4'h0

`endif

// ==== shared/dpg_pkg.sv ====
`include "dpg_regs.svh"

package dpg_pkg;

    typedef logic [`DPG_WIDE_W-1:0] dpg_wide_t;
    typedef logic [`DPG_NARROW_W-1:0] dpg_narrow_t;

    // Whole state of the port block
    typedef struct packed {
        dpg_wide_t wide_data;
        dpg_narrow_t narrow_data;
        dpg_wide_t wide_dir;
        dpg_narrow_t narrow_dir;
        dpg_wide_t wide_pdi;
        dpg_narrow_t narrow_pdi;
        logic [`DPG_OPT_W-1:0] option;
        dpg_wide_t wide_pull;
        dpg_narrow_t narrow_pull;
        logic irq_latch;
        logic active_prev;
        logic irq_req;
        logic irq_pin_level;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } dpg_state_s;

endpackage

// ==== tb/dpg_gpio_asserts.sv ====
`timescale 1ns/1ps
module dpg_gpio_asserts (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Wide port pins
    input wire logic [7:0] wide_pin_out,
    input wire logic [7:0] wide_pin_oe,
    input wire logic [7:0] wide_pin_pulldown
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic hit;
    assign hit = psel && penable && pready && pwrite && pstrb[0];
    setup_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    data_drive_a: assert property (hit && paddr[11:2] == 10'h000 |=> wide_pin_out == $past(pwdata[7:0]))
        else $error("pin out not written data");
    dir_drive_a: assert property (hit && paddr[11:2] == 10'h004 |=> wide_pin_oe == $past(pwdata[7:0]))
        else $error("pin enable not written direction");
    dir_hold_a: assert property (!(hit && paddr[11:2] == 10'h004) |=> $stable(wide_pin_oe))
        else $error("pin enable moved without write");
    pull_off_a: assert property ((wide_pin_pulldown & wide_pin_oe) == 8'h00)
        else $error("pulldown on an output");
    narrow_zero_a: assert property (pready && !pwrite && paddr[11:3] == 9'h000 && paddr[2] |-> prdata[31:2] == '0)
        else $error("narrow upper bits not zero");
    unmapped_err_a: assert property (pready && paddr[11:2] == 10'h030 |-> pslverr && prdata == '0)
        else $error("unmapped access not refused");
endmodule
bind dpg_gpio dpg_gpio_asserts chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .wide_pin_out, .wide_pin_oe, .wide_pin_pulldown);

// ==== tb/dpg_pins_model.sv ====
`timescale 1ns/1ps
module dpg_pins_model #(parameter int W = 8) (
    // Clock
    input wire logic pclk,
    // Block side
    input wire logic [W-1:0] pin_out,
    input wire logic [W-1:0] pin_oe,
    input wire logic [W-1:0] pin_pulldown,
    // External drivers
    input wire logic [W-1:0] ext_en,
    input wire logic [W-1:0] ext_val,
    // Resolved wire
    output logic [W-1:0] level
);
    logic [W-1:0] float_v = '0;
    // Released pins flip every cycle so a stale value never passes
    always @(posedge pclk) float_v <= ~float_v;
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (pin_oe[i]) level[i] = pin_out[i];
            else if (ext_en[i]) level[i] = ext_val[i];
            else if (pin_pulldown[i]) level[i] = 1'b0;
            else level[i] = float_v[i];
        end
    end
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, irq_n_pin = 1, ev;
    logic pready, pslverr, irq_request, irq_pin_level;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rv;
    logic [3:0] pstrb = '0;
    logic [7:0] wo, woe, wpd, wl, wx = '0, we = 8'hff;
    logic [1:0] no, noe, npd, nl, nx = '0;
    int miscompares = 0, check_count = 0, rg[int], x;
    int keys[5] = '{16, 20, 64, 68, 80};
    int ad[7] = '{0, 4, 16, 20, 64, 68, 80};
    always #5 pclk = ~pclk;
    dpg_gpio dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .wide_pin_in(wl), .wide_pin_out(wo), .wide_pin_oe(woe),
        .wide_pin_pulldown(wpd), .narrow_pin_in(nl), .narrow_pin_out(no), .narrow_pin_oe(noe),
        .narrow_pin_pulldown(npd), .irq_n_pin, .irq_request, .irq_pin_level);
    dpg_pins_model #(.W(8)) wide_u (.pclk, .pin_out(wo), .pin_oe(woe), .pin_pulldown(wpd),
        .ext_en(we), .ext_val(wx), .level(wl));
    dpg_pins_model #(.W(2)) narrow_u (.pclk, .pin_out(no), .pin_oe(noe), .pin_pulldown(npd),
        .ext_en(2'h3), .ext_val(nx), .level(nl));
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", miscompares, check_count);
        if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(string s, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] s);
        int n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
        do begin
            @(posedge pclk);
            penable <= 1;
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) miscompares++;
        if (n >= 50) summarize();
        rv = prdata;
        ev = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // Pin outputs against the register model
    task automatic pins(int p);
        int pd = rg[80][0] ? ~rg[64 + 4 * p] & ~rg[16 + 4 * p] : 0;
        if (p == 1 && rg[80][3]) pd[1] = 0;
        @(negedge pclk);
        chk("oe", rg[16 + 4 * p], p ? noe : woe);
        chk("out", rg[4 * p], p ? no : wo);
        chk("pulldown", pd & (p ? 3 : 255), p ? npd : wpd);
    endtask
    task automatic wr(logic [11:0] a, int d);
        apb(1, a, d, 4'h1);
        rg[a] = d & (a == 80 ? 15 : a[2] ? 3 : 255);
        pins(a[2]);
    endtask
    task automatic rd(int p);
        int dr = rg[16 + 4 * p];
        int e = dr & rg[4 * p] | ~dr & (p ? nx : wx & we);
        if (p == 1 && rg[80][3]) e[1] = rg[4][1];
        apb(0, 4 * p, '0, 4'h0);
        chk("data", e & (p ? 3 : 255), rv);
        apb(0, 16 + 4 * p, '0, 4'h0);
        chk("dir", dr, rv);
    endtask
    task automatic irq(logic e);
        repeat (4) @(posedge pclk);
        chk("irq", e, irq_request);
    endtask
    initial begin
        x = $urandom(90);
        repeat (3) @(posedge pclk);
        presetn <= 1;
        foreach (keys[i]) rg[keys[i]] = 0;
        wr(0, $urandom);
        wr(4, $urandom);
        rd(0);
        rd(1);
        for (int i = 0; i < 8; i++) begin
            wx <= $urandom;
            nx <= $urandom;
            foreach (ad[j]) wr(ad[j], $urandom);
            rd(0);
            rd(1);
        end
        apb(1, 16, ~rg[16], 4'h0);
        rd(0);
        apb(0, 12'h0c0, '0, 4'h0);
        chk("slverr", 1, ev);
        wr(80, 1);
        wr(16, 0);
        wr(64, 0);
        we <= 8'h00;
        @(posedge pclk);
        rd(0);
        we <= 8'hff;
        presetn <= 0;
        @(posedge pclk);
        presetn <= 1;
        foreach (keys[i]) rg[keys[i]] = 0;
        pins(0);
        pins(1);
        wx <= 8'h01;
        wr(80, 2);
        irq(1);
        wr(80, 6);
        wr(84, 1);
        wx <= 8'h03;
        irq(0);
        wx <= 8'h00;
        irq(0);
        wx <= 8'h04;
        irq(1);
        wx <= 8'h00;
        wr(84, 1);
        wr(0, 8);
        wr(16, 8);
        irq(1);
        wr(84, 1);
        irq_n_pin <= 0;
        irq(0);
        chk("irq_pin_level", 0, irq_pin_level);
        apb(0, 84, '0, 4'h0);
        chk("status", 4, rv);
        summarize();
    end
endmodule
